// [dlf_pkg.sv]
package dlf_pkg;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int unsigned CLK_HZ      = 10_000_000;
    localparam int unsigned SAMPLE_HZ   = 800;
    localparam int unsigned BAND_HZ     = SAMPLE_HZ / 2;
    localparam int unsigned TICK_CYCLES = CLK_HZ / SAMPLE_HZ;

    // converter step sizes per range, millivolts
    localparam int unsigned HIGH_STEP_MV = 628;
    localparam int unsigned LOW_STEP_MV  = 251;

    // ************************************************************
    // widths
    // ************************************************************
    localparam int SAMP_W = 8;
    localparam int VAL_W  = 9;
    localparam int COEF_W = 16;
    localparam int RES_W  = 16;
    localparam int FRAC_W = 8;
    localparam int ACC_W  = 24;
    localparam int NCH    = 2;

    // ************************************************************
    // register map, byte offsets inside one channel window
    // ************************************************************
    localparam logic [5:0] REG_CTRL   = 6'h00;
    localparam logic [5:0] REG_STATUS = 6'h04;
    localparam logic [5:0] REG_DCCOEF = 6'h08;
    localparam logic [5:0] REG_ACCOEF = 6'h0c;
    localparam logic [5:0] REG_DCRES  = 6'h10;
    localparam logic [5:0] REG_ACRES  = 6'h14;
    localparam logic [5:0] REG_PEAK   = 6'h18;
    localparam logic [5:0] REG_DERV   = 6'h1c;
    localparam logic [5:0] REG_DERI   = 6'h20;
    localparam int         CH_BIT     = 6;

    // field positions
    localparam int CTRL_EN_BIT    = 0;
    localparam int CTRL_SRC_LSB   = 1;
    localparam int CTRL_RANGE_BIT = 4;
    localparam int STAT_EN_BIT    = 0;
    localparam int STAT_RUN_BIT   = 1;
    localparam int STAT_STOP_BIT  = 2;
    localparam int DER_HI_LSB     = 16;

    // reset values
    localparam logic [COEF_W-1:0] COEF_RST = 16'h0800;

    typedef enum logic [2:0] {
        SRC_TIP_V  = 3'h0,
        SRC_RING_V = 3'h1,
        SRC_LOOP_V = 3'h2,
        SRC_LONG_V = 3'h3,
        SRC_LOOP_I = 3'h4,
        SRC_LONG_I = 3'h5,
        SRC_EXT_V  = 3'h6,
        SRC_EXT_I  = 3'h7
    } dlf_src_t;

    // one monitor converter sample set for one channel
    typedef struct packed {
        logic signed [SAMP_W-1:0] tipV;
        logic signed [SAMP_W-1:0] ringV;
        logic signed [SAMP_W-1:0] tipI;
        logic signed [SAMP_W-1:0] ringI;
        logic signed [SAMP_W-1:0] extV;
        logic signed [SAMP_W-1:0] extI;
    } dlf_samp_t;

    typedef struct packed {
        logic     rangeHigh;
        dlf_src_t src;
        logic     enable;
    } dlf_ctrl_t;

    // ************************************************************
    // shared arithmetic
    // ************************************************************
    function automatic logic signed [VAL_W-1:0] widen(input logic signed [SAMP_W-1:0] a);
        return {a[SAMP_W-1], a};
    endfunction

    function automatic logic signed [VAL_W-1:0] diffOf(input logic signed [SAMP_W-1:0] a,
                                                       input logic signed [SAMP_W-1:0] b);
        return widen(a) - widen(b);
    endfunction

    // sum halved; 9-bit sum keeps the carry so no overflow
    function automatic logic signed [VAL_W-1:0] halfSumOf(input logic signed [SAMP_W-1:0] a,
                                                          input logic signed [SAMP_W-1:0] b);
        logic signed [VAL_W-1:0] s;
        s = widen(a) + widen(b);
        return {s[VAL_W-1], s[VAL_W-1:1]};
    endfunction

endpackage

// [dlf_tick.sv]
`timescale 1ns/1ps
module dlf_tick
    import dlf_pkg::*;
#(
    parameter int unsigned PERIOD = TICK_CYCLES
) (
    // clock and reset
    input  wire logic mclk,
    input  wire logic rst_n,
    input  wire logic ce,
    // one-cycle pulse each period
    output logic      tick
);

    localparam int CW = $clog2(PERIOD);

    if (PERIOD < 2) $error("dlf_tick: PERIOD must be at least 2");

    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;

    // free-running divider, wraps at PERIOD-1
    always_comb begin
        if (cnt_q == CW'(PERIOD - 1)) begin
            cnt_d = '0;
        end else begin
            cnt_d = cnt_q + 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= '0;
        end else if (ce) begin
            cnt_q <= cnt_d;
        end
    end

    assign tick = ce && (cnt_q == CW'(PERIOD - 1));

endmodule // dlf_tick

// [dlf_chan.sv]
`timescale 1ns/1ps
module dlf_chan
    import dlf_pkg::*;
(
    // clock and reset
    input  wire logic                    mclk,
    input  wire logic                    rst_n,
    input  wire logic                    ce,
    // control
    input  wire logic                    run,
    input  wire logic                    flush,
    input  wire logic                    peakClr,
    input  wire logic                    sampleValid,
    input  wire logic [COEF_W-1:0]       dcCoef,
    input  wire logic [COEF_W-1:0]       acCoef,
    // selected input
    input  wire logic signed [VAL_W-1:0] x,
    // results
    output logic [VAL_W-1:0]             peak,
    output logic signed [RES_W-1:0]      dcRes,
    output logic signed [RES_W-1:0]      acRes
);

    logic [VAL_W-1:0]        peak_q;
    logic [VAL_W-1:0]        peak_d;
    logic signed [ACC_W-1:0] dc_q;
    logic signed [ACC_W-1:0] dc_d;
    logic signed [ACC_W-1:0] ac_q;
    logic signed [ACC_W-1:0] ac_d;
    logic [VAL_W-1:0]        mag;

    function automatic logic [VAL_W-1:0] absOf(input logic signed [VAL_W-1:0] v);
        return v[VAL_W-1] ? VAL_W'(-v) : VAL_W'(v);
    endfunction

    // y += (x - y) * k / 2^16, coefficient read fresh every sample
    function automatic logic signed [ACC_W-1:0] iirStep(input logic signed [ACC_W-1:0] y,
                                                        input logic signed [VAL_W-1:0] v,
                                                        input logic [COEF_W-1:0]       k);
        logic signed [ACC_W-1:0]        xs;
        logic signed [ACC_W:0]          e;
        logic signed [ACC_W+COEF_W+1:0] p;
        xs = {{(ACC_W-VAL_W-FRAC_W){v[VAL_W-1]}}, v, {FRAC_W{1'b0}}};
        e  = {xs[ACC_W-1], xs} - {y[ACC_W-1], y};
        p  = e * $signed({1'b0, k});
        return y + p[ACC_W+COEF_W-1:COEF_W];
    endfunction

    assign mag = absOf(x);

    // one step per accepted sample; flush and restart beat the step
    always_comb begin
        peak_d = peak_q;
        dc_d   = dc_q;
        ac_d   = ac_q;
        if (run && sampleValid) begin
            if (mag > peak_q) peak_d = mag;
            dc_d = iirStep(dc_q, x, dcCoef);
            ac_d = iirStep(ac_q, $signed(mag), acCoef);
        end
        if (peakClr) peak_d = '0;
        if (flush) begin
            peak_d = '0;
            dc_d   = '0;
            ac_d   = '0;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            peak_q <= '0;
            dc_q   <= '0;
            ac_q   <= '0;
        end else if (ce) begin
            peak_q <= peak_d;
            dc_q   <= dc_d;
            ac_q   <= ac_d;
        end
    end

    assign peak  = peak_q;
    assign dcRes = dc_q[ACC_W-1:FRAC_W];
    assign acRes = ac_q[ACC_W-1:FRAC_W];

endmodule // dlf_chan

// [slic_line_diagnostic_filters.sv]
// What this block does
// - converter is started at 800 Hz, giving a dc to 400 Hz band
// - loop and longitudinal quantities derived per sample, held in registers
// - per-channel range select: high range 628 mV steps, low 251 mV
// - filters advance only while the diagnostic enable is set
// - each channel has its own enable, source select and filter state
// - filters run only while the channel's voice processing is idle
// - off-hook or ring trip clears the enable and stops processing
// - source codes 0 to 7 choose which quantity feeds the filters
// - loop is tip minus ring; longitudinal is half of tip plus ring
// - peak holds the largest unsigned magnitude of the input
// - dc path: single-pole low-pass, software coefficient, readable result
// - ac path: rectify then single-pole low-pass with its own coefficient
// - enable rising or source change clears peak and flushes both filters
// - software writing zero to the peak result restarts peak accumulation
`timescale 1ns/1ps
module slic_line_diagnostic_filters
    import dlf_pkg::*;
#(
    parameter int unsigned TICK_PERIOD = TICK_CYCLES
) (
    // clock, reset, enable
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic        ce,
    // wishbone classic slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // monitor converter
    output logic             convStart,
    output logic [NCH-1:0]   rangeHigh,
    input  wire logic        sampleValid,
    input  wire dlf_samp_t   samples [NCH],
    // line supervision and dsp arbitration
    input  wire logic [NCH-1:0] offHook,
    input  wire logic [NCH-1:0] ringTrip,
    input  wire logic [NCH-1:0] voiceBusy,
    output logic [NCH-1:0]   diagRun
);

    if (TICK_PERIOD < 2) $error("TICK_PERIOD must be at least 2");

    // ************************************************************
    // sample rate generator
    // ************************************************************
    logic tick;

    dlf_tick #(
        .PERIOD (TICK_PERIOD)
    ) u_tick (
        .mclk  (mclk),
        .rst_n (rst_n),
        .ce    (ce),
        .tick  (tick)
    );

    // one start pulse per 800 Hz frame
    assign convStart = tick;

    // ************************************************************
    // register state
    // ************************************************************
    dlf_ctrl_t               ctrl_q   [NCH];
    dlf_ctrl_t               ctrl_d   [NCH];
    logic [COEF_W-1:0]       dcCoef_q [NCH];
    logic [COEF_W-1:0]       dcCoef_d [NCH];
    logic [COEF_W-1:0]       acCoef_q [NCH];
    logic [COEF_W-1:0]       acCoef_d [NCH];
    logic signed [VAL_W-1:0] loopV_q  [NCH];
    logic signed [VAL_W-1:0] loopV_d  [NCH];
    logic signed [VAL_W-1:0] longV_q  [NCH];
    logic signed [VAL_W-1:0] longV_d  [NCH];
    logic signed [VAL_W-1:0] loopI_q  [NCH];
    logic signed [VAL_W-1:0] loopI_d  [NCH];
    logic signed [VAL_W-1:0] longI_q  [NCH];
    logic signed [VAL_W-1:0] longI_d  [NCH];
    logic [NCH-1:0]          stop_q;
    logic [NCH-1:0]          stop_d;
    logic [NCH-1:0]          flush_q;
    logic [NCH-1:0]          flush_d;
    logic [NCH-1:0]          peakClr_q;
    logic [NCH-1:0]          peakClr_d;
    logic                    ack_q;
    logic                    ack_d;
    logic [31:0]             dat_q;
    logic [31:0]             dat_d;

    // results from the channel datapaths
    logic [VAL_W-1:0]        peak  [NCH];
    logic signed [RES_W-1:0] dcRes [NCH];
    logic signed [RES_W-1:0] acRes [NCH];
    logic signed [VAL_W-1:0] selX  [NCH];

    // ************************************************************
    // bus decode
    // ************************************************************
    logic       busReq;
    logic       busWr;
    logic       chSel;
    logic [5:0] offs;

    // ack is registered, so ack_q blocks a second take of the same request
    assign busReq = wb_cyc_i && wb_stb_i && !ack_q;
    assign busWr  = busReq && wb_we_i;
    assign chSel  = wb_adr_i[CH_BIT];
    assign offs   = wb_adr_i[CH_BIT-1:0];

    // byte-lane merge for partially written words
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  sel);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) r[b*8 +: 8] = nw[b*8 +: 8];
        end
        return r;
    endfunction

    function automatic logic [31:0] ctrlWord(input dlf_ctrl_t c);
        logic [31:0] w;
        w = '0;
        w[CTRL_EN_BIT]                 = c.enable;
        w[CTRL_SRC_LSB +: 3]           = c.src;
        w[CTRL_RANGE_BIT]              = c.rangeHigh;
        return w;
    endfunction

    function automatic logic [31:0] pairWord(input logic signed [VAL_W-1:0] lo,
                                             input logic signed [VAL_W-1:0] hi);
        logic [31:0] w;
        w = '0;
        w[DER_HI_LSB-1:0]  = 16'($signed(lo));
        w[31:DER_HI_LSB]   = 16'($signed(hi));
        return w;
    endfunction

    // ************************************************************
    // control and register next state
    // ************************************************************
    always_comb begin
        logic [31:0] w;
        logic        hit;
        w         = '0;
        hit       = 1'b0;
        ack_d     = busReq;
        stop_d    = stop_q;
        flush_d   = '0;
        peakClr_d = '0;
        for (int c = 0; c < NCH; c++) begin
            ctrl_d[c]   = ctrl_q[c];
            dcCoef_d[c] = dcCoef_q[c];
            acCoef_d[c] = acCoef_q[c];
            loopV_d[c]  = loopV_q[c];
            longV_d[c]  = longV_q[c];
            loopI_d[c]  = loopI_q[c];
            longI_d[c]  = longI_q[c];
            hit         = busWr && (chSel == c[0]);

            if (hit && offs == REG_CTRL) begin
                w = merge(ctrlWord(ctrl_q[c]), wb_dat_i, wb_sel_i);
                ctrl_d[c].enable    = w[CTRL_EN_BIT];
                ctrl_d[c].src       = dlf_src_t'(w[CTRL_SRC_LSB +: 3]);
                ctrl_d[c].rangeHigh = w[CTRL_RANGE_BIT];
                if (w[CTRL_EN_BIT]) stop_d[c] = 1'b0;
                // flush on enable rising or on a changed source
                if ((w[CTRL_EN_BIT] && !ctrl_q[c].enable) ||
                    (w[CTRL_SRC_LSB +: 3] != ctrl_q[c].src)) begin
                    flush_d[c] = 1'b1;
                end
            end
            // coefficient is only sampled at the next step
            if (hit && offs == REG_DCCOEF) begin
                w = merge(32'(dcCoef_q[c]), wb_dat_i, wb_sel_i);
                dcCoef_d[c] = w[COEF_W-1:0];
            end
            if (hit && offs == REG_ACCOEF) begin
                w = merge(32'(acCoef_q[c]), wb_dat_i, wb_sel_i);
                acCoef_d[c] = w[COEF_W-1:0];
            end
            if (hit && offs == REG_PEAK && merge('0, wb_dat_i, wb_sel_i) == '0) begin
                peakClr_d[c] = 1'b1;
            end

            // line event wins over a software set in the same cycle
            if ((ctrl_q[c].enable || ctrl_d[c].enable) && (offHook[c] || ringTrip[c])) begin
                ctrl_d[c].enable = 1'b0;
                stop_d[c]        = 1'b1;
            end

            // derived quantities refresh on every new sample set
            if (sampleValid) begin
                loopV_d[c] = diffOf(samples[c].tipV, samples[c].ringV);
                longV_d[c] = halfSumOf(samples[c].tipV, samples[c].ringV);
                loopI_d[c] = diffOf(samples[c].tipI, samples[c].ringI);
                longI_d[c] = halfSumOf(samples[c].tipI, samples[c].ringI);
            end
        end
    end

    // ************************************************************
    // register bank
    // ************************************************************
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            for (int c = 0; c < NCH; c++) begin
                ctrl_q[c]   <= '{rangeHigh: 1'b0, src: SRC_TIP_V, enable: 1'b0};
                dcCoef_q[c] <= COEF_RST;
                acCoef_q[c] <= COEF_RST;
                loopV_q[c]  <= '0;
                longV_q[c]  <= '0;
                loopI_q[c]  <= '0;
                longI_q[c]  <= '0;
            end
            stop_q    <= '0;
            flush_q   <= '0;
            peakClr_q <= '0;
            ack_q     <= 1'b0;
            dat_q     <= '0;
        end else if (ce) begin
            for (int c = 0; c < NCH; c++) begin
                ctrl_q[c]   <= ctrl_d[c];
                dcCoef_q[c] <= dcCoef_d[c];
                acCoef_q[c] <= acCoef_d[c];
                loopV_q[c]  <= loopV_d[c];
                longV_q[c]  <= longV_d[c];
                loopI_q[c]  <= loopI_d[c];
                longI_q[c]  <= longI_d[c];
            end
            stop_q    <= stop_d;
            flush_q   <= flush_d;
            peakClr_q <= peakClr_d;
            ack_q     <= ack_d;
            dat_q     <= dat_d;
        end
    end

    // ************************************************************
    // read mux, unmapped offsets read zero
    // ************************************************************
    always_comb begin
        int unsigned c;
        c     = 32'(chSel);
        dat_d = dat_q;
        if (busReq && !wb_we_i) begin
            unique case (offs)
                REG_CTRL:   dat_d = ctrlWord(ctrl_q[c]);
                REG_STATUS: begin
                    dat_d = '0;
                    dat_d[STAT_EN_BIT]   = ctrl_q[c].enable;
                    dat_d[STAT_RUN_BIT]  = diagRun[c];
                    dat_d[STAT_STOP_BIT] = stop_q[c];
                end
                REG_DCCOEF: dat_d = 32'(dcCoef_q[c]);
                REG_ACCOEF: dat_d = 32'(acCoef_q[c]);
                REG_DCRES:  dat_d = 32'($signed(dcRes[c]));
                REG_ACRES:  dat_d = 32'($signed(acRes[c]));
                REG_PEAK:   dat_d = 32'(peak[c]);
                REG_DERV:   dat_d = pairWord(loopV_q[c], longV_q[c]);
                REG_DERI:   dat_d = pairWord(loopI_q[c], longI_q[c]);
                default:    dat_d = '0;
            endcase
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;

    // ************************************************************
    // per-channel filter datapaths
    // ************************************************************
    for (genvar g = 0; g < NCH; g++) begin : g_ch
        // input select from the live sample set
        always_comb begin
            unique case (ctrl_q[g].src)
                SRC_TIP_V:  selX[g] = widen(samples[g].tipV);
                SRC_RING_V: selX[g] = widen(samples[g].ringV);
                SRC_LOOP_V: selX[g] = diffOf(samples[g].tipV, samples[g].ringV);
                SRC_LONG_V: selX[g] = halfSumOf(samples[g].tipV, samples[g].ringV);
                SRC_LOOP_I: selX[g] = diffOf(samples[g].tipI, samples[g].ringI);
                SRC_LONG_I: selX[g] = halfSumOf(samples[g].tipI, samples[g].ringI);
                SRC_EXT_V:  selX[g] = widen(samples[g].extV);
                SRC_EXT_I:  selX[g] = widen(samples[g].extI);
            endcase
        end

        // dsp is shared with voice, so diagnostics yield to it
        assign diagRun[g]   = ctrl_q[g].enable && !voiceBusy[g];
        assign rangeHigh[g] = ctrl_q[g].rangeHigh;

        dlf_chan u_chan (
            .mclk        (mclk),
            .rst_n       (rst_n),
            .ce          (ce),
            .run         (diagRun[g]),
            .flush       (flush_q[g]),
            .peakClr     (peakClr_q[g]),
            .sampleValid (sampleValid),
            .dcCoef      (dcCoef_q[g]),
            .acCoef      (acCoef_q[g]),
            .x           (selX[g]),
            .peak        (peak[g]),
            .dcRes       (dcRes[g]),
            .acRes       (acRes[g])
        );
    end

endmodule // slic_line_diagnostic_filters

// [dlf_conv_model.sv]
`timescale 1ns/1ps
module dlf_conv_model
    import dlf_pkg::*;
(
    // clock and reset
    input  wire logic      mclk,
    input  wire logic      rst_n,
    // converter control and data
    input  wire logic      convStart,
    input  wire dlf_samp_t feed,
    output logic           sampleValid,
    output dlf_samp_t      samples [NCH]
);
    // ********
    // converter
    // ********
    logic [1:0] dly;
    // a sample set lands three cycles after each start
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            dly <= 2'h0;
            sampleValid <= 1'b0;
        end else begin
            dly <= {dly[0], convStart};
            sampleValid <= dly[1];
        end
    end
    // channel 0 data is inverted outside the strobe, channel 1 data inside it, so stale use shows
    always_comb begin
        samples[0] = sampleValid ? feed : ~feed;
        samples[1] = sampleValid ? ~feed : feed;
    end
endmodule // dlf_conv_model

// [dlf_chk.sv]
`timescale 1ns/1ps
module dlf_chk
    import dlf_pkg::*;
#(
    parameter int PERIOD = 20
) (
    // clock and reset
    input wire logic        mclk,
    input wire logic        rst_n,
    input wire logic        ce,
    // bus
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    // converter and line
    input wire logic        convStart,
    input wire logic [1:0]  rangeHigh,
    input wire logic [1:0]  offHook,
    input wire logic [1:0]  ringTrip,
    input wire logic [1:0]  voiceBusy,
    input wire logic [1:0]  diagRun
);
    // ********
    // checks
    // ********
    localparam int GAP = PERIOD - 8;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o && ce; endsequence
    sequence s_wctl; s_req ##0 wb_we_i && wb_adr_i == 8'h00 && wb_sel_i[0]; endsequence
    sequence s_runm; s_req ##0 !wb_we_i && wb_adr_i == 8'h3c; endsequence
    property p_ack; s_req |=> wb_ack_o; endproperty
    property p_pulse; wb_ack_o |=> !wb_ack_o; endproperty
    property p_idle; !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o; endproperty
    property p_unm; s_runm |=> wb_ack_o && wb_dat_o == 32'h0; endproperty
    property p_range; s_wctl |=> rangeHigh[0] == $past(wb_dat_i[4]); endproperty
    property p_busy; (voiceBusy & diagRun) == 2'b00; endproperty
    property p_hook; offHook[0] || ringTrip[0] |=> !diagRun[0]; endproperty
    property p_tick; convStart |=> !convStart [*8] ##GAP convStart; endproperty
    a_ack: assert property (p_ack) else $error("request not answered");
    a_pulse: assert property (p_pulse) else $error("ack longer than one cycle");
    a_idle: assert property (p_idle) else $error("ack without request");
    a_unm: assert property (p_unm) else $error("unmapped read not zero");
    a_range: assert property (p_range) else $error("range select wrong");
    a_busy: assert property (p_busy) else $error("run during voice");
    a_hook: assert property (p_hook) else $error("run after hook event");
    a_tick: assert property (p_tick) else $error("start period wrong");
endmodule // dlf_chk

bind slic_line_diagnostic_filters dlf_chk #(.PERIOD(TICK_PERIOD)) dlf_chk_i (.mclk, .rst_n,
    .ce, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
    .wb_ack_o, .convStart, .rangeHigh, .offHook, .ringTrip, .voiceBusy, .diagRun);

// [slic_line_diagnostic_filters_test.sv]
`timescale 1ns/1ps
module slic_line_diagnostic_filters_test;
    import dlf_pkg::*;
    // ********
    // bench signals
    // ********
    logic        mclk = 1'b0;
    logic        rst_n = 1'b0;
    logic        ce = 1'b1;
    logic        wbCyc = 1'b0;
    logic        wbStb = 1'b0;
    logic        wbWe = 1'b0;
    logic [7:0]  wbAdr = 8'h00;
    logic [3:0]  wbSel = 4'hf;
    logic [31:0] wbDat = 32'h0;
    logic [31:0] wbRd, rd;
    logic        wbAck, convStart, sampleValid;
    logic [1:0]  rangeHigh, diagRun;
    logic [1:0]  offHook = 2'h0;
    logic [1:0]  ringTrip = 2'h0;
    logic [1:0]  voiceBusy = 2'h3;
    dlf_samp_t   feed = '0;
    dlf_samp_t   used;
    dlf_samp_t   samples [NCH];
    int          errors = 0;
    int          checked = 0;
    int          seed = 54127;
    slic_line_diagnostic_filters #(.TICK_PERIOD(20)) slic_line_diagnostic_filters_i (.mclk,
        .rst_n, .ce, .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr),
        .wb_sel_i(wbSel), .wb_dat_i(wbDat), .wb_dat_o(wbRd), .wb_ack_o(wbAck), .convStart,
        .rangeHigh, .sampleValid, .samples, .offHook, .ringTrip, .voiceBusy, .diagRun);
    dlf_conv_model dlf_conv_model_i (.mclk, .rst_n, .convStart, .feed, .sampleValid, .samples);
    initial forever #50 mclk = ~mclk;
    // ********
    // helpers
    // ********
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        if (errors == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // one classic cycle; the slave sets the pace, the watchdog guards a hang
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        {wbCyc, wbStb, wbWe, wbAdr, wbDat} <= {2'b11, w, a, d};
        do begin
            @(posedge mclk);
        end while (wbAck !== 1'b1);
        rd = wbRd;
        {wbCyc, wbStb} <= 2'b00;
    endtask
    // the quantity a source code selects, worked out independently
    function automatic logic signed [8:0] pick(input logic [2:0] s, input dlf_samp_t f);
        logic signed [8:0] t, r, ti, ri;
        {t, r, ti, ri} = {9'(f.tipV), 9'(f.ringV), 9'(f.tipI), 9'(f.ringI)};
        case (s)
            3'h0: return t;
            3'h1: return r;
            3'h2: return t - r;
            3'h3: return (t + r) >>> 1;
            3'h4: return ti - ri;
            3'h5: return (ti + ri) >>> 1;
            3'h6: return 9'(f.extV);
            default: return 9'(f.extI);
        endcase
    endfunction
    function automatic logic [8:0] mag(input logic signed [8:0] v);
        return v < 0 ? -v : v;
    endfunction
    // lets channel 0 see exactly n samples, then holds it busy again
    task automatic step(input int n, input logic [2:0] s, input logic rnd, inout logic [8:0] pk);
        @(posedge mclk iff sampleValid);
        voiceBusy[0] <= 1'b0;
        if (rnd) feed <= {$random(seed), 16'($random(seed))};
        repeat (n) begin
            @(posedge mclk iff sampleValid);
            used = feed;
            if (mag(pick(s, feed)) > pk) pk = mag(pick(s, feed));
            if (rnd) feed <= {$random(seed), 16'($random(seed))};
        end
        voiceBusy[0] <= 1'b1;
    endtask
    // ********
    // scenarios
    // ********
    initial begin
        logic [8:0] pk, pk2;
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        bus(1'b0, 8'h08, 32'h0);
        check(rd, 32'h0800);
        bus(1'b0, 8'h3c, 32'h0);
        check(rd, 32'h0);
        for (int s = 0; s < 8; s++) begin
            bus(1'b1, 8'h00, {27'h0, s[0], s[2:0], 1'b1});
            check({31'h0, rangeHigh[0]}, {31'h0, s[0]});
            pk = 9'h0;
            step(1, s[2:0], 1'b1, pk);
            bus(1'b0, 8'h18, 32'h0);
            check(rd, {23'h0, pk});
            bus(1'b0, 8'h1c, 32'h0);
            check(rd, {16'(pick(3'h3, used)), 16'(pick(3'h2, used))});
            bus(1'b0, 8'h20, 32'h0);
            check(rd, {16'(pick(3'h5, used)), 16'(pick(3'h4, used))});
        end
        bus(1'b1, 8'h08, 32'h8000);
        bus(1'b1, 8'h0c, 32'h8000);
        bus(1'b1, 8'h00, 32'h5);
        feed <= {8'hec, 8'h14, 32'h0};
        pk = 9'h0;
        step(2, 3'h2, 1'b0, pk);
        bus(1'b0, 8'h10, 32'h0);
        check({16'h0, rd[15:0]}, 32'hffe2);
        bus(1'b0, 8'h14, 32'h0);
        check({16'h0, rd[15:0]}, 32'h001e);
        bus(1'b1, 8'h18, 32'h0);
        bus(1'b0, 8'h18, 32'h0);
        check(rd, 32'h0);
        pk = 9'h0;
        step(3, 3'h2, 1'b1, pk);
        bus(1'b0, 8'h18, 32'h0);
        check(rd, {23'h0, pk});
        bus(1'b1, 8'h00, 32'h4);
        step(2, 3'h2, 1'b1, pk2);
        bus(1'b0, 8'h18, 32'h0);
        check(rd, {23'h0, pk});
        for (int h = 0; h < 2; h++) begin
            bus(1'b1, 8'h00, 32'h5);
            {offHook[0], ringTrip[0]} <= h ? 2'b01 : 2'b10;
            repeat (2) @(posedge mclk);
            {offHook[0], ringTrip[0]} <= 2'b00;
            bus(1'b0, 8'h04, 32'h0);
            check(rd, 32'h4);
        end
        bus(1'b0, 8'h58, 32'h0);
        check(rd, 32'h0);
        conclude();
    end
    // hang guard
    initial begin
        repeat (20000) @(posedge mclk);
        errors++;
        conclude();
    end
endmodule // slic_line_diagnostic_filters_test
